/* File: design/speed_divider.sv */
// Unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module speed_divider
(
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        start,
   input  wire logic [63:0] dividend,
   input  wire logic [23:0] divisor,
   output logic             done,
   output logic [63:0]      quotient
);

   logic [24:0] rem_r;
   logic [63:0] quot_r;
   logic [6:0]  cnt_r;
   logic        run_r;
   logic        done_r;
   logic [24:0] trial;
   logic [24:0] shifted;

   always_comb
   begin
      shifted = {rem_r[23:0], quot_r[63]};
      trial   = shifted - {1'b0, divisor};
   end

   // ----------------------------------------------------------------
   // Iteration
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rem_r  <= '0;
         quot_r <= '0;
         cnt_r  <= '0;
         run_r  <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         if (start)
         begin
            rem_r  <= '0;
            quot_r <= dividend;
            cnt_r  <= speed_est_pkg::DIV_STEPS;
            run_r  <= 1'b1;
         end
         else if (run_r)
         begin
            if (trial[24])
            begin
               rem_r  <= shifted;
               quot_r <= {quot_r[62:0], 1'b0};
            end
            else
            begin
               rem_r  <= trial;
               quot_r <= {quot_r[62:0], 1'b1};
            end
            cnt_r <= cnt_r - 7'h01;
            if (cnt_r == 7'h01)
            begin
               run_r  <= 1'b0;
               done_r <= 1'b1;
            end
         end
      end
   end

   assign done     = done_r;
   assign quotient = quot_r;

endmodule

/* File: design/speed_est_pkg.sv */
// Shared types and constants of the encoder speed estimator
package speed_est_pkg;

   // ----------------------------------------------------------------
   // Fixed-point formats
   // ----------------------------------------------------------------
   localparam int unsigned FRAC_W    = 24;
   localparam logic [23:0] FRAC_MIN  = 24'h800000;
   localparam logic [23:0] FRAC_MAX  = 24'h7fffff;
   localparam logic [23:0] FRAC_ZERO = 24'h000000;

   // 1.23: minus one up to one minus 2^-23
   typedef logic signed [23:0] fract123_type;
   // 3.21: minus four up to four minus 2^-21
   typedef logic signed [23:0] fixed321_type;

   typedef struct packed {
      fixed321_type alpha;
      fixed321_type beta;
   } volt_vec_type;

   typedef struct packed {
      logic signed [23:0] countAccum;
      logic [23:0]        lastEdge;
   } decoder_in_type;

   // ----------------------------------------------------------------
   // Arithmetic sizes
   // ----------------------------------------------------------------
   localparam int unsigned PROD_W     = 48;
   localparam int unsigned DIV_W      = 64;
   localparam int unsigned GAIN_SHIFT = 16;
   localparam logic [6:0]  DIV_STEPS  = 7'h40;

   // ----------------------------------------------------------------
   // Scheduling and timing
   // ----------------------------------------------------------------
   localparam logic [1:0]  UPDATE_PHASE    = 2'h0;
   localparam int unsigned CLK_PERIOD_NS   = 20;
   localparam int unsigned PWM_PERIOD_NS   = 50000;
   localparam int unsigned PWM_PERIOD_CYC  = PWM_PERIOD_NS / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_MUL  = 4'h2,
      ST_DIV  = 4'h4,
      ST_SAT  = 4'h8
   } est_state_type;

endpackage

/* File: design/speed_estimator.sv */
// Periodic encoder speed estimator with 3.21 voltage hand-over
`timescale 1ns/1ps
module speed_estimator
(
   input  wire logic                         mclk,
   input  wire logic                         arst_n,
   input  wire logic                         pwmPeriodStart,
   input  wire logic                         speedLink,
   input  wire speed_est_pkg::decoder_in_type decoderIn,
   input  wire logic [23:0]                  speedGain,
   input  wire speed_est_pkg::volt_vec_type  voltIn,
   output logic                              accumClear,
   output speed_est_pkg::fract123_type       speedOut,
   output logic                              speedValid,
   output logic                              busy,
   output logic                              overrun,
   output speed_est_pkg::volt_vec_type       voltOut
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   speed_est_pkg::est_state_type state_r;
   logic [1:0]                   phase_r;
   logic                         accept;
   logic signed [23:0]           countDelta_r;
   logic signed [23:0]           timeDelta_r;
   logic [23:0]                  prevEdge_r;
   logic                         negative_r;
   logic [47:0]                  product_r;
   logic                         divStart_r;
   logic                         divDone;
   logic [63:0]                  quotient;
   logic                         accumClear_r;
   speed_est_pkg::fract123_type  speed_r;
   logic                         speedValid_r;
   logic                         busy_r;
   logic                         overrun_r;
   speed_est_pkg::volt_vec_type  volt_r;
   logic signed [23:0]           timeDiff;
   logic                         tooBig;
   logic [23:0]                  satValue;
   logic [11:0]                  busyCycles_r;

   function automatic logic [23:0] magnitude(input logic signed [23:0] v);
      magnitude = v[23] ? 24'(-v) : 24'(v);
   endfunction

   // Wrapping difference keeps working when the timebase rolls over
   assign timeDiff = $signed(decoderIn.lastEdge - prevEdge_r);
   assign accept   = speedLink && (phase_r == speed_est_pkg::UPDATE_PHASE)
                     && (state_r == speed_est_pkg::ST_IDLE);

   // ----------------------------------------------------------------
   // Period phase
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         phase_r <= 2'h0;
      else if (pwmPeriodStart)
         phase_r <= phase_r + 2'h1;
   end

   // ----------------------------------------------------------------
   // Sampling of decoder state
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         countDelta_r <= '0;
         timeDelta_r  <= '0;
         prevEdge_r   <= '0;
         accumClear_r <= 1'b0;
      end
      else
      begin
         accumClear_r <= accept;
         if (accept)
         begin
            countDelta_r <= decoderIn.countAccum;
            timeDelta_r  <= timeDiff;
            prevEdge_r   <= decoderIn.lastEdge;
         end
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r    <= speed_est_pkg::ST_IDLE;
         product_r  <= '0;
         negative_r <= 1'b0;
         divStart_r <= 1'b0;
      end
      else
      begin
         divStart_r <= 1'b0;
         unique case (state_r)
            speed_est_pkg::ST_IDLE:
            begin
               if (accept)
                  state_r <= speed_est_pkg::ST_MUL;
            end
            speed_est_pkg::ST_MUL:
            begin
               product_r  <= magnitude(countDelta_r) * speedGain;
               negative_r <= countDelta_r[23] ^ timeDelta_r[23];
               if (timeDelta_r == '0)
                  state_r <= speed_est_pkg::ST_IDLE;
               else
               begin
                  divStart_r <= 1'b1;
                  state_r    <= speed_est_pkg::ST_DIV;
               end
            end
            speed_est_pkg::ST_DIV:
            begin
               if (divDone)
                  state_r <= speed_est_pkg::ST_SAT;
            end
            speed_est_pkg::ST_SAT:
               state_r <= speed_est_pkg::ST_IDLE;
            default:
               state_r <= speed_est_pkg::ST_IDLE;
         endcase
      end
   end

   speed_divider speed_divider_inst
   (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .start    (divStart_r),
      .dividend ({product_r, 16'h0000}),
      .divisor  (magnitude(timeDelta_r)),
      .done     (divDone),
      .quotient (quotient)
   );

   // ----------------------------------------------------------------
   // Saturation into 1.23
   // ----------------------------------------------------------------
   always_comb
   begin
      if (negative_r)
      begin
         tooBig   = quotient > 64'({1'b0, speed_est_pkg::FRAC_MIN});
         satValue = tooBig ? speed_est_pkg::FRAC_MIN : 24'(-quotient[23:0]);
      end
      else
      begin
         tooBig   = quotient > 64'(speed_est_pkg::FRAC_MAX);
         satValue = tooBig ? speed_est_pkg::FRAC_MAX : quotient[23:0];
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         speed_r      <= speed_est_pkg::FRAC_ZERO;
         speedValid_r <= 1'b0;
      end
      else
      begin
         speedValid_r <= 1'b0;
         if (state_r == speed_est_pkg::ST_SAT)
         begin
            speed_r      <= satValue;
            speedValid_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Status
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         busy_r    <= 1'b0;
         overrun_r <= 1'b0;
      end
      else
      begin
         busy_r    <= accept || ((state_r != speed_est_pkg::ST_IDLE) && (state_r != speed_est_pkg::ST_SAT)
                      && !(state_r == speed_est_pkg::ST_MUL && timeDelta_r == '0));
         // Pulses when a period boundary finds an update still running
         overrun_r <= pwmPeriodStart && (state_r != speed_est_pkg::ST_IDLE);
      end
   end

   // ----------------------------------------------------------------
   // Voltage vector hand-over in 3.21
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         volt_r <= '0;
      else if (pwmPeriodStart)
         volt_r <= voltIn;
   end

   assign accumClear = accumClear_r;
   assign speedOut   = speed_r;
   assign speedValid = speedValid_r;
   assign busy       = busy_r;
   assign overrun    = overrun_r;
   assign voltOut    = volt_r;

   // ----------------------------------------------------------------
   // Update length, watched against the pwm period
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         busyCycles_r <= '0;
      else if (!busy_r)
         busyCycles_r <= '0;
      else
         busyCycles_r <= busyCycles_r + 12'h001;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   clear_after_read_a: assert property (accept |=> accumClear_r ##1 !accumClear_r)
      else $error("accumulator clear not a single pulse after read");
   delta_capture_a: assert property (accept |=> countDelta_r == $past(decoderIn.countAccum))
      else $error("count delta not taken from accumulator");
   edge_store_a: assert property (accept |=> prevEdge_r == $past(decoderIn.lastEdge)
                                  && timeDelta_r == $past(timeDiff))
      else $error("edge time not stored");
   phase_gate_a: assert property (accumClear_r |-> $past(phase_r) == speed_est_pkg::UPDATE_PHASE)
      else $error("update outside its period");
   period_finish_a: assert property (accept |-> ##[1:70] state_r == speed_est_pkg::ST_IDLE)
      else $error("update did not finish in time");
   zero_dt_hold_a: assert property ((state_r == speed_est_pkg::ST_MUL && timeDelta_r == '0)
                                    |=> $stable(speed_r) && !speedValid_r ##1 !speedValid_r)
      else $error("speed changed on zero time delta");
   speed_sign_a: assert property ((speedValid_r && !$past(negative_r)) |-> !speed_r[23])
      else $error("positive speed has sign bit");
   sat_limit_a: assert property ((state_r == speed_est_pkg::ST_SAT && tooBig && !negative_r)
                                 |=> speed_r == speed_est_pkg::FRAC_MAX)
      else $error("positive overflow not saturated");
   sat_low_a: assert property ((state_r == speed_est_pkg::ST_SAT && tooBig && negative_r)
                               |=> speed_r == speed_est_pkg::FRAC_MIN)
      else $error("negative overflow not saturated");
   volt_pass_a: assert property (pwmPeriodStart |=> volt_r == $past(voltIn))
      else $error("voltage vector not handed over");
   volt_hold_a: assert property (!pwmPeriodStart |=> $stable(volt_r))
      else $error("voltage vector changed mid period");

   // Deadline, pulse shape, phase gating and in-range speed values of the update
   deadline_a: assert property (busyCycles_r < 12'(speed_est_pkg::PWM_PERIOD_CYC))
      else $error("update ran past one pwm period");
   div_latency_a: assert property (divStart_r |-> ##65 divDone)
      else $error("divider did not finish on time");
   overrun_set_a: assert property ((pwmPeriodStart && state_r != speed_est_pkg::ST_IDLE) |=> overrun_r)
      else $error("overrun not flagged");
   overrun_clear_a: assert property (!pwmPeriodStart |=> !overrun_r)
      else $error("overrun flagged without period start");
   busy_span_a: assert property (accumClear_r |-> busy_r)
      else $error("busy low during an update");
   idle_quiet_a: assert property ((state_r == speed_est_pkg::ST_IDLE && !accept) |=> !busy_r)
      else $error("busy high while idle");
   refuse_link_a: assert property ((speedLink && phase_r != speed_est_pkg::UPDATE_PHASE) |=> !accumClear_r)
      else $error("link taken outside update period");
   phase_step_a: assert property (pwmPeriodStart |=> phase_r == $past(phase_r) + 2'h1)
      else $error("period phase did not advance");
   valid_pulse_a: assert property (speedValid_r |=> !speedValid_r)
      else $error("speed valid longer than one cycle");
   sat_pass_a: assert property ((state_r == speed_est_pkg::ST_SAT && !tooBig && !negative_r)
                                |=> speed_r == $past(quotient[23:0]))
      else $error("in-range positive speed altered");
   sat_negate_a: assert property ((state_r == speed_est_pkg::ST_SAT && !tooBig && negative_r)
                                  |=> speed_r == 24'(-$past(quotient[23:0])))
      else $error("in-range negative speed altered");

   // Main scenarios

   update_c: cover property (accept ##[1:70] speedValid_r);
   zero_dt_c: cover property (state_r == speed_est_pkg::ST_MUL && timeDelta_r == '0);
   saturate_c: cover property (state_r == speed_est_pkg::ST_SAT && tooBig);
   refused_c: cover property (speedLink && phase_r != speed_est_pkg::UPDATE_PHASE);
   overrun_c: cover property (overrun_r);

endmodule

/* File: verification/quad_decoder_model.sv */
// Behavioural quadrature decoder channel feeding the speed estimator
`timescale 1ns/1ps
module quad_decoder_model
(
   input  wire logic                     mclk,
   input  wire logic                     arst_n,
   input  wire logic                     countStrobe,
   input  wire logic [23:0]              countAdd,
   input  wire logic [23:0]              edgeTime,
   input  wire logic                     accumClear,
   output speed_est_pkg::decoder_in_type decoderIn
);
   logic [23:0] accum_r;
   logic [23:0] edge_r;

   // Counts arriving in the clear cycle survive the clear
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         accum_r <= 24'h000000;
      else if (countStrobe)
         accum_r <= (accumClear ? 24'h000000 : accum_r) + countAdd;
      else if (accumClear)
         accum_r <= 24'h000000;
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         edge_r <= 24'h000000;
      else if (countStrobe)
         edge_r <= edgeTime;
   end

   assign decoderIn = {accum_r, edge_r};
endmodule

/* File: verification/speed_estimator_tb_top.sv */
// Self-checking testbench of the encoder speed estimator
`timescale 1ns/1ps
module speed_estimator_tb_top;
   logic                          mclk, arst_n, pwmPeriodStart, speedLink, countStrobe;
   logic                          accumClear, speedValid, busy, overrun;
   logic [23:0]                   countAdd, edgeTime, speedGain, prevEdge;
   speed_est_pkg::fract123_type   speedOut, lastSpeed;
   speed_est_pkg::volt_vec_type   voltIn, voltOut;
   speed_est_pkg::decoder_in_type decoderIn;
   int                            nMismatch, checkCount, phase;

   speed_estimator speed_estimator_inst (.mclk(mclk), .arst_n(arst_n), .pwmPeriodStart(pwmPeriodStart),
      .speedLink(speedLink), .decoderIn(decoderIn), .speedGain(speedGain), .voltIn(voltIn),
      .accumClear(accumClear), .speedOut(speedOut), .speedValid(speedValid), .busy(busy),
      .overrun(overrun), .voltOut(voltOut));

   quad_decoder_model quad_decoder_model_inst (.mclk(mclk), .arst_n(arst_n), .countStrobe(countStrobe),
      .countAdd(countAdd), .edgeTime(edgeTime), .accumClear(accumClear), .decoderIn(decoderIn));

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [47:0] seen, input logic [47:0] expected);
      checkCount++;
      if (seen !== expected)
      begin
         nMismatch++;
         $display("unexpected at %0t ns: saw %h, expected %h", $time, seen, expected);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checkCount, nMismatch);
      if (nMismatch == 0 && checkCount > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   function automatic logic [23:0] exp_speed(input logic signed [23:0] d, input logic signed [23:0] dt,
                                             input logic [23:0] g);
      longint      sd;
      longint      sdt;
      logic [63:0] q;
      sd = d;
      sdt = dt;
      q = (((sd < 0) ? -sd : sd) * g << 16) / ((sdt < 0) ? -sdt : sdt);
      if ((sd < 0) == (sdt < 0))
         return (q > 64'h00000000007fffff) ? 24'h7fffff : q[23:0];
      q = (q > 64'h0000000000800000) ? 64'h0000000000800000 : q;
      q = -q;
      return q[23:0];
   endfunction

   // One period start; overrun and the voltage copy are seen one cycle later
   task automatic period_pulse(input logic expOv);
      @(posedge mclk);
      pwmPeriodStart <= 1'b1;
      @(posedge mclk);
      pwmPeriodStart <= 1'b0;
      phase = (phase + 1) % 4;
      #1;
      check(overrun, expOv);
      check(voltOut, voltIn);
   endtask

   task automatic link_pulse();
      @(posedge mclk);
      speedLink <= 1'b1;
      @(posedge mclk);
      speedLink <= 1'b0;
      #1;
   endtask

   task automatic feed(input logic [23:0] cnt, input logic [23:0] edgeT);
      @(posedge mclk);
      countStrobe <= 1'b1;
      countAdd <= cnt;
      edgeTime <= edgeT;
      @(posedge mclk);
      countStrobe <= 1'b0;
   endtask

   task automatic run_update(input logic signed [23:0] cnt, input logic [23:0] edgeT);
      logic signed [23:0] dt;
      logic [23:0]        expSpeed;
      dt = edgeT - prevEdge;
      expSpeed = (dt == 24'h000000) ? lastSpeed : exp_speed(cnt, dt, speedGain);
      feed(cnt, edgeT);
      period_pulse(1'b0);
      while (phase != 0)
         period_pulse(1'b0);
      link_pulse();
      check(accumClear, 1'b1);
      check(busy, 1'b1);
      repeat (68) @(posedge mclk);
      #1;
      check(speedValid, dt != 24'h000000);
      check($unsigned(speedOut), expSpeed);
      check(busy, 1'b0);
      check(decoderIn.countAccum, 24'h000000);
      prevEdge = edgeT;
      lastSpeed = expSpeed;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_updates();
      logic [23:0] cnt [6] = '{24'h000064, 24'hffffce, 24'h0003e8, 24'hfffc18, 24'hfffff6, 24'h000005};
      logic [23:0] edg [6] = '{24'h0003e8, 24'h0005dc, 24'h000640, 24'h0006a4, 24'h000640, 24'h000640};
      for (int i = 0; i < 6; i++)
         run_update(cnt[i], edg[i]);
      $display("test updates done");
   endtask

   task automatic test_refuse();
      logic [23:0] vt [3] = '{24'h800000, 24'h7fffff, 24'h200000};
      for (int i = 0; i < 3; i++)
      begin
         @(posedge mclk);
         voltIn <= {vt[i], ~vt[i]};
         period_pulse(1'b0);
         link_pulse();
         check(accumClear, 1'b0);
         check(busy, 1'b0);
      end
      $display("test refuse done");
   endtask

   task automatic test_overrun();
      feed(24'h000014, 24'h0007d0);
      while (phase != 0)
         period_pulse(1'b0);
      link_pulse();
      period_pulse(1'b1);
      link_pulse();
      check(accumClear, 1'b0);
      repeat (100) if (busy === 1'b1) @(negedge mclk);
      check(busy, 1'b0);
      check(speedValid, 1'b1);
      check($unsigned(speedOut), exp_speed(24'h000014, 24'h000190, speedGain));
      $display("test overrun done");
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      arst_n = 1'b0;
      pwmPeriodStart = 1'b0;
      speedLink = 1'b0;
      countStrobe = 1'b0;
      countAdd = 24'h000000;
      edgeTime = 24'h000000;
      speedGain = 24'h000100;
      voltIn = '0;
      prevEdge = 24'h000000;
      lastSpeed = 24'h000000;
      nMismatch = 0;
      checkCount = 0;
      phase = 0;
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      test_updates();
      test_refuse();
      test_overrun();
      finish_test();
   end

   initial
   begin
      repeat (5000) @(posedge mclk);
      nMismatch++;
      finish_test();
   end
endmodule
